// *** hw/msc_pkg.sv ***
// Shared constants and types for the snoop and coherency controller
package msc_pkg;
  localparam int ADDR_W = 32;
  localparam int BLOCK_BYTES = 32;
  localparam int OFFS_W = $clog2(BLOCK_BYTES);
  // Directory index is A20:A26 in big-endian numbering, bits 11:5 here
  localparam int IDX_LSB = OFFS_W;
  localparam int IDX_W = 7;
  // Tag is PA0-PA19, bits 31:12 here
  localparam int TAG_LSB = IDX_LSB + IDX_W;
  localparam int TAG_W = ADDR_W - TAG_LSB;
  localparam int NUM_WAYS = 4;
  localparam int WAY_W = 2;
  localparam int TT_W = 5;
  localparam logic [TT_W-1:0] TT_CI_READ = 5'h0a;
  localparam logic [TT_W-1:0] TT_READ = 5'h0a;
  localparam logic [TT_W-1:0] TT_RWITM = 5'h0e;
  localparam logic [TT_W-1:0] TT_WRITE_FLUSH = 5'h02;
  localparam logic [TT_W-1:0] TT_WRITE_KILL = 5'h06;

  // Reset value of every line is the first code, invalid
  typedef enum logic [1:0] {
    LINE_INVALID,
    LINE_EXCLUSIVE,
    LINE_MODIFIED
  } msc_three_state_coherency_t;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    msc_three_state_coherency_t st;
  } msc_entry_t;

  typedef struct packed {
    logic writeThrough;
    logic cacheInhibit;
    logic coherent;
  } msc_page_storage_attrs_t;

  typedef enum logic [1:0] {OP_LOAD, OP_STORE, OP_IFETCH, OP_INVAL} msc_core_op_t;

  typedef struct packed {
    msc_core_op_t op;
    logic [ADDR_W-1:0] addr;
    msc_page_storage_attrs_t attrs;
    logic realMode;
  } msc_core_req_t;

  typedef struct packed {
    logic transferStartStrobe;
    logic gbl;
    logic [TT_W-1:0] transferTypeCode;
    logic [ADDR_W-1:0] addr;
  } msc_snoop_t;

  typedef struct packed {
    logic [TT_W-1:0] tt;
    logic [ADDR_W-1:0] addr;
    logic gbl;
    logic burst;
    logic [WAY_W-1:0] cse;
    logic cseValid;
  } msc_bus_req_t;
endpackage

// *** hw/msc_tag_dir.sv ***
// Single-ported tag directory held in flip-flops
`timescale 1ns/100ps
module msc_tag_dir #(
  parameter int NUM_WAYS = msc_pkg::NUM_WAYS,
  parameter int IDX_W = msc_pkg::IDX_W
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [IDX_W-1:0] idx,
  input wire logic wrEn,
  input wire logic [$clog2(NUM_WAYS)-1:0] wrWay,
  input msc_pkg::msc_entry_t wrEntry,
  output msc_pkg::msc_entry_t [NUM_WAYS-1:0] rdSet
);
  import msc_pkg::*;

  typedef struct packed {
    msc_entry_t [(1<<IDX_W)-1:0][NUM_WAYS-1:0] ent;
  } msc_dir_state_t;

  msc_dir_state_t d_r;
  msc_dir_state_t d_nxt;

  if (NUM_WAYS < 2 || (NUM_WAYS & (NUM_WAYS - 1)) != 0) begin : g_chk
    $error("msc_tag_dir: way count must be a power of two");
  end

  // Read and write share the one index: a single port
  assign rdSet = d_r.ent[idx];

  always_comb begin
    d_nxt = d_r;
    if (wrEn) begin
      d_nxt.ent[idx][wrWay] = wrEntry;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      d_r <= '0; // R23
    end else begin
      d_r <= d_nxt;
    end
  end
endmodule

// *** hw/msc_snoop_ctrl.sv ***
// Snoop and coherency controller for a four-set data cache
// Operation
// (R1) Every data cache block fill goes out as read-with-intent-to-modify.
// (R2) A filled block is owned; stores to it need no bus broadcast.
// (R3) Snooped global reads act as writes: modified pushes and invalidates; TT_READ equals TT_CI_READ here, so such reads keep the block.
// (R4) Snooped inhibited read keeps the block: modified pushes, becomes exclusive.
// (R5) 32-byte blocks; A20:A26 index, PA0-PA19 compared; no match is a miss.
// (R6) Each tag holds two state bits, reported on a match.
// (R7) Snoop beats core for the tags; core access follows next clock; here it waits while a snoop hit updates the tags or pushes.
// (R8) Snoop meeting a tag write is retried and re-arbitrates.
// (R9) Snoop during a burst read or write is retried.
// (R10) Snoop on block entering copy-back buffer: retry, raise cast-out priority.
// (R11) Other masters mark shared traffic global; unmarked traffic is not snooped.
// (R12) Instruction fetches never global; real-mode data accesses always global.
// (R13) Translated data accesses take global from the coherency bit.
// (R14) Snoop starts only with start strobe and global in one clock.
// (R15) Own cast-outs and snoop pushes go out non-global.
// (R16) Qualified snoop compares captured address; miss ends, hit acts.
// (R17) Burst fills carry the replaced set in binary; invalid otherwise.
// (R18) Cache-management operations stay local with no bus broadcast.
// (R19) Write-through store hitting modified pushes the block, stays modified.
// (R20) Software flushes blocks before making a page caching-inhibited.
// (R21) Load miss reads the bus, retries on address retry, marks exclusive.
// (R22) Write-with-flush hitting modified: assert retry, push, invalidate.
// (R23) All blocks are invalid after reset before any coherency action.
`timescale 1ns/100ps
module msc_snoop_ctrl #(
  parameter int NUM_WAYS = msc_pkg::NUM_WAYS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic coreReqValid,
  input msc_pkg::msc_core_req_t coreReq,
  input msc_pkg::msc_snoop_t snoopIn,
  input wire logic busDone,
  input wire logic busArtryIn,
  output logic coreDone,
  output logic coreHit,
  output msc_pkg::msc_three_state_coherency_t coreState,
  output logic busReqValid,
  output msc_pkg::msc_bus_req_t busReq,
  output logic artryOut,
  output logic castoutPriority
);
  import msc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SNP_UPD,
    ST_PUSH,
    ST_COPYBACK,
    ST_CASTOUT,
    ST_FILL,
    ST_FILL_VAL,
    ST_CORE_UPD,
    ST_SINGLE
  } msc_fsm_t;

  typedef struct packed {
    msc_fsm_t fsm;
    msc_core_req_t req;
    logic [ADDR_W-1:0] snpAddr;
    logic [ADDR_W-1:0] coAddr;
    msc_three_state_coherency_t snpNext;
    logic snpPush;
    logic snpCi;
    logic [WAY_W-1:0] hitWay;
    logic [WAY_W-1:0] victim;
    logic [WAY_W-1:0] rrPtr;
    logic busReqValid;
    msc_bus_req_t bus;
    logic artry;
    logic coPrio;
    logic coreDone;
    logic coreHit;
    msc_three_state_coherency_t coreState;
  } msc_ctrl_state_t;

  msc_ctrl_state_t s_r;
  msc_ctrl_state_t s_nxt;
  logic [IDX_W-1:0] dirIdx;
  logic dirWrEn;
  logic [WAY_W-1:0] dirWrWay;
  msc_entry_t dirWrEntry;
  msc_entry_t [NUM_WAYS-1:0] dirRd;
  logic snpQual;
  logic coreTake;
  logic [WAY_W:0] look;
  msc_entry_t hitEnt;

  if (NUM_WAYS != (1 << WAY_W)) begin : g_chk
    $error("msc_snoop_ctrl: set code needs exactly four ways");
  end

  function automatic logic [TAG_W-1:0] tagOf(input logic [ADDR_W-1:0] a);
    return a[TAG_LSB +: TAG_W];
  endfunction

  function automatic logic [IDX_W-1:0] idxOf(input logic [ADDR_W-1:0] a);
    return a[IDX_LSB +: IDX_W];
  endfunction

  // Hit flag on top, matching way below
  function automatic logic [WAY_W:0] findHit(input msc_entry_t [NUM_WAYS-1:0] set,
                                             input logic [TAG_W-1:0] tag);
    logic [WAY_W:0] r;
    r = '0;
    for (int w = NUM_WAYS - 1; w >= 0; w--) begin
      if (set[w].st != LINE_INVALID && set[w].tag == tag) begin
        r = {1'b1, WAY_W'(w)}; // R5
      end
    end
    return r;
  endfunction

  // Lowest invalid way, else the round-robin pointer
  function automatic logic [WAY_W-1:0] pickVictim(input msc_entry_t [NUM_WAYS-1:0] set,
                                                  input logic [WAY_W-1:0] rr);
    logic [WAY_W-1:0] v;
    logic found;
    v = rr;
    found = 1'b0;
    for (int w = 0; w < NUM_WAYS; w++) begin
      if (!found && set[w].st == LINE_INVALID) begin
        v = WAY_W'(w);
        found = 1'b1;
      end
    end
    return v;
  endfunction

  function automatic logic coreGbl(input msc_core_req_t r);
    if (r.op == OP_IFETCH) begin
      return 1'b0; // R12
    end
    if (r.realMode) begin
      return 1'b1; // R12
    end
    return r.attrs.coherent; // R13
  endfunction

  function automatic msc_bus_req_t mkReq(input logic [TT_W-1:0] tt,
                                         input logic [ADDR_W-1:0] a,
                                         input logic gbl,
                                         input logic burst);
    msc_bus_req_t r;
    r = '0;
    r.tt = tt;
    r.addr = burst ? {a[ADDR_W-1:OFFS_W], OFFS_W'(0)} : a;
    r.gbl = gbl;
    r.burst = burst;
    return r;
  endfunction

  function automatic msc_bus_req_t fillReq(input msc_core_req_t q,
                                           input logic [WAY_W-1:0] way);
    msc_bus_req_t r;
    r = mkReq(TT_RWITM, q.addr, coreGbl(q), 1'b1); // R1
    r.cse = way; // R17
    r.cseValid = 1'b1; // R17
    return r;
  endfunction

  msc_tag_dir #(.NUM_WAYS(NUM_WAYS), .IDX_W(IDX_W)) u_dir (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .idx(dirIdx),
    .wrEn(dirWrEn),
    .wrWay(dirWrWay),
    .wrEntry(dirWrEntry),
    .rdSet(dirRd)
  );

  assign snpQual = snoopIn.transferStartStrobe && snoopIn.gbl; // R14 R11
  assign coreTake = s_r.fsm == ST_IDLE && !snpQual && coreReqValid && !s_r.coreDone; // R7

  // Tag port owner for this cycle
  always_comb begin
    if (s_r.fsm == ST_IDLE && snpQual) begin
      dirIdx = idxOf(snoopIn.addr); // R7
    end else if (s_r.fsm == ST_IDLE) begin
      dirIdx = idxOf(coreReq.addr);
    end else if (s_r.fsm == ST_COPYBACK) begin
      dirIdx = idxOf(snoopIn.addr);
    end else if (s_r.fsm == ST_SNP_UPD) begin
      dirIdx = idxOf(s_r.snpAddr);
    end else begin
      dirIdx = idxOf(s_r.req.addr);
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.artry = 1'b0;
    s_nxt.coreDone = 1'b0;
    dirWrEn = 1'b0;
    dirWrWay = s_r.victim;
    dirWrEntry = '0;
    look = '0;
    hitEnt = '0;
    if (snpQual && s_r.fsm != ST_IDLE) begin
      s_nxt.artry = 1'b1; // R8 R9
    end
    case (s_r.fsm)
      ST_IDLE: begin
        if (snpQual) begin
          look = findHit(dirRd, tagOf(snoopIn.addr)); // R16
          s_nxt.snpAddr = snoopIn.addr;
          s_nxt.hitWay = look[WAY_W-1:0];
          s_nxt.snpCi = snoopIn.transferTypeCode == TT_CI_READ;
          s_nxt.snpPush = dirRd[look[WAY_W-1:0]].st == LINE_MODIFIED;
          // Inhibited read of an exclusive block changes nothing
          if (look[WAY_W] && (s_nxt.snpPush || !s_nxt.snpCi)) begin
            s_nxt.fsm = ST_SNP_UPD;
            s_nxt.artry = s_nxt.snpPush; // R22
            if (s_nxt.snpCi) begin
              s_nxt.snpNext = LINE_EXCLUSIVE; // R4
            end else begin
              s_nxt.snpNext = LINE_INVALID; // R3
            end
          end
        end else if (coreTake) begin
          look = findHit(dirRd, tagOf(coreReq.addr));
          hitEnt = dirRd[look[WAY_W-1:0]];
          s_nxt.req = coreReq;
          s_nxt.hitWay = look[WAY_W-1:0];
          s_nxt.coreHit = look[WAY_W];
          s_nxt.coreState = look[WAY_W] ? hitEnt.st : LINE_INVALID; // R6
          s_nxt.victim = pickVictim(dirRd, s_r.rrPtr);
          s_nxt.coAddr = {dirRd[s_nxt.victim].tag, idxOf(coreReq.addr), OFFS_W'(0)};
          if (coreReq.op == OP_INVAL) begin
            // Local only, never broadcast
            if (look[WAY_W]) begin
              s_nxt.fsm = ST_CORE_UPD; // R18
            end else begin
              s_nxt.coreDone = 1'b1; // R18
            end
          end else if (coreReq.op == OP_IFETCH || coreReq.attrs.cacheInhibit) begin
            s_nxt.bus = mkReq(coreReq.op == OP_STORE ? TT_WRITE_FLUSH : TT_READ,
                              coreReq.addr, coreGbl(coreReq), coreReq.op == OP_IFETCH);
            s_nxt.busReqValid = 1'b1;
            s_nxt.fsm = ST_SINGLE;
          end else if (coreReq.op == OP_STORE && coreReq.attrs.writeThrough) begin
            // Modified block is pushed whole and keeps its state
            s_nxt.bus = mkReq(TT_WRITE_FLUSH, coreReq.addr, coreGbl(coreReq),
                              look[WAY_W] && hitEnt.st == LINE_MODIFIED); // R19
            s_nxt.busReqValid = 1'b1;
            s_nxt.fsm = ST_SINGLE;
          end else if (look[WAY_W]) begin
            if (coreReq.op == OP_STORE && hitEnt.st == LINE_EXCLUSIVE) begin
              s_nxt.fsm = ST_CORE_UPD; // R2
            end else begin
              s_nxt.coreDone = 1'b1; // R2
            end
          end else begin
            s_nxt.rrPtr = s_r.rrPtr + 1'b1;
            if (dirRd[s_nxt.victim].st == LINE_MODIFIED) begin
              s_nxt.fsm = ST_COPYBACK;
            end else begin
              s_nxt.bus = fillReq(coreReq, s_nxt.victim); // R1
              s_nxt.busReqValid = 1'b1;
              s_nxt.fsm = ST_FILL;
            end
          end
        end
      end
      ST_SNP_UPD: begin
        dirWrEn = 1'b1;
        dirWrWay = s_r.hitWay;
        dirWrEntry = {tagOf(s_r.snpAddr), s_r.snpNext}; // R3 R4
        if (s_r.snpPush) begin
          s_nxt.bus = mkReq(TT_WRITE_KILL, s_r.snpAddr, 1'b0, 1'b1); // R15
          s_nxt.busReqValid = 1'b1;
          s_nxt.fsm = ST_PUSH;
        end else begin
          s_nxt.fsm = ST_IDLE;
        end
      end
      ST_COPYBACK: begin
        // Victim moves to the copy-back buffer; tags are free for a look
        if (snpQual) begin
          look = findHit(dirRd, tagOf(snoopIn.addr));
          if (look[WAY_W] && look[WAY_W-1:0] == s_r.victim &&
              idxOf(snoopIn.addr) == idxOf(s_r.req.addr)) begin
            s_nxt.coPrio = 1'b1; // R10
          end
        end
        s_nxt.bus = mkReq(TT_WRITE_KILL, s_r.coAddr, 1'b0, 1'b1); // R15
        s_nxt.busReqValid = 1'b1;
        s_nxt.fsm = ST_CASTOUT;
      end
      ST_CASTOUT: begin
        if (busDone && !busArtryIn) begin
          s_nxt.coPrio = 1'b0;
          s_nxt.bus = fillReq(s_r.req, s_r.victim); // R10
          s_nxt.fsm = ST_FILL;
        end
      end
      ST_FILL: begin
        // Address retry leaves the request standing for re-issue
        if (busDone && !busArtryIn) begin
          s_nxt.busReqValid = 1'b0; // R21
          s_nxt.fsm = ST_FILL_VAL;
        end
      end
      ST_FILL_VAL: begin
        dirWrEn = 1'b1;
        dirWrEntry.tag = tagOf(s_r.req.addr);
        dirWrEntry.st = s_r.req.op == OP_STORE ? LINE_MODIFIED : LINE_EXCLUSIVE; // R21 R2
        s_nxt.coreState = dirWrEntry.st;
        s_nxt.coreDone = 1'b1;
        s_nxt.fsm = ST_IDLE;
      end
      ST_CORE_UPD: begin
        dirWrEn = 1'b1;
        dirWrWay = s_r.hitWay;
        dirWrEntry.tag = tagOf(s_r.req.addr);
        dirWrEntry.st = s_r.req.op == OP_INVAL ? LINE_INVALID : LINE_MODIFIED; // R2 R18
        s_nxt.coreState = dirWrEntry.st;
        s_nxt.coreDone = 1'b1;
        s_nxt.fsm = ST_IDLE;
      end
      ST_SINGLE: begin
        if (busDone && !busArtryIn) begin
          s_nxt.busReqValid = 1'b0;
          s_nxt.coreDone = 1'b1;
          s_nxt.fsm = ST_IDLE;
        end
      end
      ST_PUSH: begin
        if (busDone && !busArtryIn) begin
          s_nxt.busReqValid = 1'b0;
          s_nxt.fsm = ST_IDLE;
        end
      end
      default: begin
        s_nxt.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_r <= '0; // R23
    end else begin
      s_r <= s_nxt;
    end
  end

  assign coreDone = s_r.coreDone;
  assign coreHit = s_r.coreHit;
  assign coreState = s_r.coreState;
  assign busReqValid = s_r.busReqValid;
  assign busReq = s_r.bus;
  assign artryOut = s_r.artry;
  assign castoutPriority = s_r.coPrio;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_FILL_RWITM: assert property ( // R1
    busReqValid && s_r.fsm == ST_FILL |->
      busReq.tt == TT_RWITM && busReq.cseValid && busReq.cse == s_r.victim
  ) else $error("fill not issued as RWITM with set code");
  AST_CSE_FILL_ONLY: assert property ( // R17
    busReqValid && s_r.fsm != ST_FILL |-> !busReq.cseValid
  ) else $error("set code valid outside a fill");
  AST_CASTOUT_LOCAL: assert property ( // R15
    busReqValid && s_r.fsm inside {ST_CASTOUT, ST_PUSH} |-> !busReq.gbl && busReq.burst
  ) else $error("cast-out or push marked global");
  AST_RETRY_BURST: assert property ( // R9
    snpQual && s_r.fsm inside {ST_FILL, ST_CASTOUT, ST_PUSH} |=> artryOut
  ) else $error("snoop during burst not retried");
  AST_RETRY_TAGWR: assert property ( // R8
    snpQual && dirWrEn |=> artryOut && s_r.fsm != ST_SNP_UPD
  ) else $error("snoop during tag write not retried");
  AST_SNOOP_WINS: assert property ( // R7
    snpQual && coreReqValid && s_r.fsm == ST_IDLE |=>
      s_r.req == $past(s_r.req) && s_r.fsm inside {ST_IDLE, ST_SNP_UPD}
  ) else $error("core took the tags from a snoop");
  AST_LOCAL_UPDATE: assert property ( // R2
    s_r.fsm == ST_CORE_UPD |-> !busReqValid ##1 !busReqValid && coreDone
  ) else $error("local tag update used the bus");
  AST_CI_KEEP: assert property ( // R4
    s_r.fsm == ST_SNP_UPD && s_r.snpCi |-> dirWrEntry.st == LINE_EXCLUSIVE && s_r.snpPush
  ) else $error("inhibited read snoop changed block wrongly");
  AST_SNOOP_PUSH: assert property ( // R3
    s_r.fsm == ST_SNP_UPD && s_r.snpPush && !s_r.snpCi |->
      dirWrEntry.st == LINE_INVALID ##1
      busReqValid && busReq.addr == {s_r.snpAddr[ADDR_W-1:OFFS_W], OFFS_W'(0)}
  ) else $error("modified snoop hit not pushed and invalidated");
  AST_UNQUALIFIED: assert property ( // R14
    !snpQual && !coreReqValid && s_r.fsm == ST_IDLE |=> s_r.fsm == ST_IDLE && !artryOut
  ) else $error("unqualified snoop acted on");
  AST_IFETCH_LOCAL: assert property ( // R12
    s_r.fsm == ST_SINGLE && s_r.req.op == OP_IFETCH |-> !busReq.gbl
  ) else $error("instruction fetch marked global");
endmodule

// *** verif/msc_bus_model.sv ***
// Bus partner that completes or retries the controller's own requests
`timescale 1ns/100ps
module msc_bus_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic busReqValid,
  input wire logic [3:0] delay,
  input wire logic retryOnce,
  output logic busDone,
  output logic busArtryIn
);
  logic [3:0] cnt_r;
  logic retried_r;

  always_ff @(posedge ref_clk) begin
    busDone <= 1'b0;
    busArtryIn <= 1'b0;
    if (!reset_n) begin
      cnt_r <= 4'h0;
      retried_r <= 1'b0;
    end else if (busReqValid && !busDone && !busArtryIn) begin
      if (cnt_r >= delay) begin
        cnt_r <= 4'h0;
        if (retryOnce && !retried_r) begin
          busArtryIn <= 1'b1;
          retried_r <= 1'b1;
        end else begin
          busDone <= 1'b1;
          retried_r <= 1'b0;
        end
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule

// *** verif/msc_snoop_ctrl_test.sv ***
// Self-checking bench for the snoop and coherency controller
`timescale 1ns/100ps
module msc_snoop_ctrl_test;
  import msc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic coreReqValid = 1'b0;
  msc_core_req_t coreReq = '0;
  msc_snoop_t snoopIn = '0;
  logic busDone, busArtryIn, coreDone, coreHit, busReqValid, artryOut, castoutPriority;
  msc_three_state_coherency_t coreState;
  msc_bus_req_t busReq;
  logic [3:0] busDelay = 4'h2;
  logic retryOnce = 1'b0;
  logic qualPrev = 1'b0;
  logic rm = 1'b0;
  logic coh = 1'b0;
  logic [19:0] tagA;
  logic [3:0] cn;
  logic [43:0] bn;
  int seed = 32'h3b45_3e1e;
  int failCount = 0;
  int checkCount = 0;
  // Notes: core {care, hit, state}; bus {addr, prio, tt, gbl, burst, cseValid, cseCare, cse}
  logic [3:0] coreQ[$];
  logic [43:0] busQ[$];
  logic artryQ[$];

  msc_snoop_ctrl i_msc_snoop_ctrl (.ref_clk(ref_clk), .reset_n(reset_n),
    .coreReqValid(coreReqValid), .coreReq(coreReq), .snoopIn(snoopIn), .busDone(busDone),
    .busArtryIn(busArtryIn), .coreDone(coreDone), .coreHit(coreHit), .coreState(coreState),
    .busReqValid(busReqValid), .busReq(busReq), .artryOut(artryOut),
    .castoutPriority(castoutPriority));
  msc_bus_model i_msc_bus_model (.ref_clk(ref_clk), .reset_n(reset_n),
    .busReqValid(busReqValid), .delay(busDelay), .retryOnce(retryOnce), .busDone(busDone),
    .busArtryIn(busArtryIn));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic expire();
    failCount++;
    $display("mismatch at %0t: wait limit reached", $time);
    conclude();
  endtask

  function automatic logic [31:0] ad(input logic [19:0] t, input logic [4:0] off);
    return {t, 7'h11, off};
  endfunction

  task automatic mix();
    rm = 1'($random(seed));
    coh = 1'($random(seed));
    busDelay <= 4'($random(seed) & 3) + 4'h1;
  endtask

  task automatic coreOp(input msc_core_op_t op, input logic [31:0] a, input logic wt,
      input logic ci, input logic [3:0] note);
    int n;
    coreQ.push_back(note);
    @(posedge ref_clk);
    coreReqValid <= 1'b1;
    coreReq <= '{op, a, '{wt, ci, coh}, rm};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (coreDone !== 1'b1 && n < 300);
    coreReqValid <= 1'b0;
    if (n >= 300) expire();
  endtask

  task automatic snoop(input logic g, input logic [4:0] tt, input logic [31:0] a,
      input logic art);
    if (g) artryQ.push_back(art);
    @(posedge ref_clk);
    snoopIn <= '{1'b1, g, tt, a};
    @(posedge ref_clk);
    snoopIn <= '{1'b0, 1'b0, ~tt, ~a};
  endtask

  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (busReqValid !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300) expire();
    repeat (2) @(posedge ref_clk);
  endtask

  // Watches the outputs and matches them against the oldest notes
  always @(posedge ref_clk) begin
    if (coreDone === 1'b1) begin
      if (coreQ.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        cn = coreQ.pop_front();
        if (cn[3]) check({13'h0, coreHit, coreState}, {13'h0, cn[2:0]});
      end
    end
    if (busReqValid === 1'b1 && busDone && !busArtryIn) begin
      if (busQ.size() == 0) begin
        check(16'h0002, 16'h0000);
      end else begin
        bn = busQ.pop_front();
        check({5'h0, castoutPriority, busReq.tt, busReq.gbl, busReq.burst, busReq.cseValid,
          bn[2] ? busReq.cse : 2'b00}, {5'h0, bn[11:3], bn[1:0]});
        check(busReq.addr[31:16], bn[43:28]);
        check(busReq.addr[15:0], bn[27:12]);
      end
    end
    if (reset_n && qualPrev && artryQ.size() > 0) begin
      check({15'h0, artryOut}, {15'h0, artryQ.pop_front()});
    end else if (reset_n) begin
      check({15'h0, artryOut}, 16'h0000);
    end
    qualPrev <= reset_n && snoopIn.transferStartStrobe && snoopIn.gbl;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    expire();
  end

  initial begin
    tagA = 20'($random(seed));
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check({13'h0, coreDone, busReqValid, artryOut}, 16'h0000);
    mix();
    retryOnce <= 1'b1;
    busQ.push_back({ad(tagA, 5'h00), 1'b0, TT_RWITM, rm | coh, 3'b111, 2'd0});
    coreOp(OP_LOAD, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b10, LINE_EXCLUSIVE});
    retryOnce <= 1'b0;
    coreOp(OP_LOAD, ad(tagA, 5'h1c), 1'b0, 1'b0, {2'b11, LINE_EXCLUSIVE});
    coreOp(OP_STORE, ad(tagA, 5'h04), 1'b0, 1'b0, {2'b11, LINE_MODIFIED});
    snoop(1'b0, TT_RWITM, ad(tagA, 5'h00), 1'b0);
    coreOp(OP_LOAD, ad(tagA, 5'h08), 1'b0, 1'b0, {2'b11, LINE_MODIFIED});
    // Inhibited read keeps the block, dirty data is pushed out first
    busQ.push_back({ad(tagA, 5'h00), 1'b0, TT_WRITE_KILL, 1'b0, 3'b100, 2'd0});
    snoop(1'b1, TT_CI_READ, ad(tagA, 5'h00), 1'b1);
    settle();
    coreOp(OP_LOAD, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b11, LINE_EXCLUSIVE});
    snoop(1'b1, TT_CI_READ, ad(tagA, 5'h00), 1'b0);
    coreOp(OP_LOAD, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b11, LINE_EXCLUSIVE});
    // Back-to-back strobes: the second meets the tag write of the first
    artryQ.push_back(1'b0);
    artryQ.push_back(1'b1);
    @(posedge ref_clk);
    snoopIn <= '{1'b1, 1'b1, TT_RWITM, ad(tagA, 5'h10)};
    @(posedge ref_clk);
    snoopIn <= '{1'b1, 1'b1, TT_RWITM, ad(tagA, 5'h00)};
    @(posedge ref_clk);
    snoopIn <= '{1'b0, 1'b0, ~TT_RWITM, ~ad(tagA, 5'h00)};
    mix();
    busQ.push_back({ad(tagA, 5'h00), 1'b0, TT_RWITM, rm | coh, 3'b111, 2'd0});
    coreOp(OP_LOAD, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b10, LINE_EXCLUSIVE});
    coreOp(OP_STORE, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b11, LINE_MODIFIED});
    busQ.push_back({ad(tagA, 5'h00), 1'b0, TT_WRITE_KILL, 1'b0, 3'b100, 2'd0});
    snoop(1'b1, TT_WRITE_FLUSH, ad(tagA, 5'h00), 1'b1);
    settle();
    mix();
    busQ.push_back({ad(tagA, 5'h00), 1'b0, TT_RWITM, rm | coh, 3'b111, 2'd0});
    coreOp(OP_LOAD, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b10, LINE_EXCLUSIVE});
    // Snoop and load ask for the tags in the same cycle
    fork
      coreOp(OP_LOAD, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b11, LINE_EXCLUSIVE});
      snoop(1'b1, TT_READ, ad(tagA ^ 20'h1, 5'h00), 1'b0);
    join
    coreOp(OP_STORE, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b11, LINE_MODIFIED});
    mix();
    busQ.push_back({ad(tagA, 5'h00), 1'b0, TT_WRITE_FLUSH, rm | coh, 3'b100, 2'd0});
    coreOp(OP_STORE, ad(tagA, 5'h00), 1'b1, 1'b0, {2'b11, LINE_MODIFIED});
    coreOp(OP_INVAL, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b11, LINE_INVALID});
    mix();
    busQ.push_back({ad(tagA, 5'h00), 1'b0, TT_RWITM, rm | coh, 3'b111, 2'd0});
    coreOp(OP_LOAD, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b10, LINE_EXCLUSIVE});
    rm = 1'b1;
    busQ.push_back({ad(tagA ^ 20'h2, 5'h00), 1'b0, TT_READ, 1'b0, 3'b100, 2'd0});
    coreOp(OP_IFETCH, ad(tagA ^ 20'h2, 5'h00), 1'b0, 1'b0, 4'h0);
    coh = 1'b0;
    busQ.push_back({ad(tagA ^ 20'h3, 5'h08), 1'b0, TT_READ, 1'b1, 3'b000, 2'd0});
    coreOp(OP_LOAD, ad(tagA ^ 20'h3, 5'h08), 1'b0, 1'b1, 4'h0);
    // Fill the other three sets, then evict a dirty block
    for (int k = 1; k < 4; k++) begin
      mix();
      busQ.push_back({ad(tagA ^ 20'(k + 3), 5'h00), 1'b0, TT_RWITM, rm | coh, 3'b111,
        2'(k)});
      coreOp(OP_STORE, ad(tagA ^ 20'(k + 3), 5'h00), 1'b0, 1'b0,
        {2'b10, LINE_MODIFIED});
    end
    coreOp(OP_STORE, ad(tagA, 5'h00), 1'b0, 1'b0, {2'b11, LINE_MODIFIED});
    mix();
    @(posedge ref_clk);
    busDelay <= 4'h4;
    // Round-robin victim is set 3, holding a dirty block
    busQ.push_back({ad(tagA ^ 20'h6, 5'h00), 1'b1, TT_WRITE_KILL, 1'b0, 3'b100, 2'd0});
    busQ.push_back({ad(tagA ^ 20'h7, 5'h00), 1'b0, TT_RWITM, rm | coh, 3'b111, 2'd3});
    fork
      coreOp(OP_LOAD, ad(tagA ^ 20'h7, 5'h00), 1'b0, 1'b0, {2'b10, LINE_EXCLUSIVE});
      begin
        // First snoop lands in the copy-back cycle and hits the victim
        @(posedge ref_clk);
        snoop(1'b1, TT_RWITM, ad(tagA ^ 20'h6, 5'h00), 1'b1);
        repeat (3) @(posedge ref_clk);
        snoop(1'b1, TT_RWITM, ad(tagA ^ 20'h8, 5'h00), 1'b1);
      end
    join
    settle();
    check(16'(coreQ.size() + busQ.size() + artryQ.size()), 16'h0000);
    conclude();
  end
endmodule
